// >>> src/wit_watch_interval_timer.sv
// Module: watch timer with 5-bit counter, 11-bit prescaler, interval taps
// Functional notes
// - The mode register resets to zero and takes both bit and byte writes.
// - Count clock is clock/128 when the source bit is 0, else subsystem.
// - The watch function pulses its request at the recurring period its code selects.
// - Watch counts only while both run bits are 1, else counter is zero.
// - Clearing only the counter run bit zeroes the counter, not prescaler.
// - Watch period code 00/01/10/11 gives 2^14/2^13/2^5/2^4 count ticks.
// - The interval function pulses its own request every selected period.
// - Interval period is 2^(4+code) count ticks, 2^4 up to 2^11.
// - Interval counting follows the timer run bit only.
`timescale 1ns/10ps
module wit_watch_interval_timer
   import wit_pkg::*;
#(
   parameter int DIV_BITS = WIT_DIV_BITS
) (
   input wire logic clock, // 25 MHz peripheral clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic byteWrite, // Whole-byte write strobe
   input wire logic [7:0] byteData, // Byte write data
   input wire logic bitWrite, // Single-bit write strobe
   input wire logic [2:0] bitIndex, // Bit written by bitWrite
   input wire logic bitValue, // Value written by bitWrite
   input wire logic subClockTick, // Subsystem clock edge, one cycle
   output logic [7:0] watch_timer_mode, // Mode register readback
   output logic watch_overflow_irq, // Watch request pulse
   output logic interval_irq // Interval request pulse
);
   logic [DIV_BITS-1:0] divCount;
   logic divTick;
   logic countTick;
   logic [WIT_PRE_BITS-1:0] prescaler;
   logic [WIT_CNT_BITS-1:0] watchCount;
   logic bothRun;
   logic watchHit;
   logic intervalHit;
   logic [WIT_PRE_BITS-1:0] intervalMask;
   logic [7:0] next_mode;
   wit_mode_s mode;

   assign mode = wit_mode_s'(watch_timer_mode);
   assign bothRun = mode.timerRunEnable & mode.counterRunEnable;

   // Byte write wins over a bit write in the same cycle
   always_comb begin
      next_mode = watch_timer_mode;
      if (byteWrite) begin
         next_mode = byteData;
      end else if (bitWrite) begin
         next_mode[bitIndex] = bitValue;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         watch_timer_mode <= WIT_MODE_RESET;
      end else begin
         watch_timer_mode <= next_mode;
      end
   end

   // Free-running divider so the source can switch without a restart
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         divCount <= '0;
      end else begin
         divCount <= divCount + 1'b1;
      end
   end

   assign divTick = &divCount;
   assign countTick = mode.countClockSourceSel ? subClockTick
                                               : divTick;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prescaler <= '0;
      end else if (!mode.timerRunEnable) begin
         prescaler <= '0;
      end else if (countTick) begin
         prescaler <= prescaler + 1'b1;
      end
   end

   // Counter advances on the 2^9 carry of the prescaler
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         watchCount <= '0;
      end else if (!bothRun) begin
         watchCount <= '0;
      end else if (countTick && &(prescaler | ~WIT_MASK_TAP)) begin
         watchCount <= watchCount + 1'b1;
      end
   end

   always_comb begin
      watchHit = 1'b0;
      case (mode.overflowIntervalSel)
         WIT_WSEL_2P14: begin
            watchHit = &(prescaler | ~WIT_MASK_TAP) &&
                       watchCount == WIT_CNT_FULL;
         end
         WIT_WSEL_2P13: begin
            watchHit = &(prescaler | ~WIT_MASK_TAP) &&
                       (watchCount & WIT_CNT_HALF) == WIT_CNT_HALF;
         end
         WIT_WSEL_2P5: watchHit = &(prescaler | ~WIT_MASK_2P5);
         WIT_WSEL_2P4: watchHit = &(prescaler | ~WIT_MASK_2P4);
         default: watchHit = 1'b0;
      endcase
   end

   // Tap at stage 4+code: low (4+code) prescaler bits all ones
   assign intervalMask = WIT_MASK_FULL >> (3'h7 - mode.intervalSel);
   assign intervalHit = &(prescaler | ~intervalMask);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         watch_overflow_irq <= 1'b0;
      end else begin
         watch_overflow_irq <= countTick & bothRun & watchHit;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         interval_irq <= 1'b0;
      end else begin
         interval_irq <= countTick & mode.timerRunEnable &
                         intervalHit;
      end
   end

   AST_RESET_ZERO: assert property (
      @(posedge clock) $rose(resetn) |-> watch_timer_mode == WIT_MODE_RESET)
      else $error("mode register not zero after reset");

   AST_BYTE_WRITE: assert property (
      @(posedge clock) disable iff (!resetn)
      byteWrite |=> watch_timer_mode == $past(byteData))
      else $error("byte write not stored");

   AST_BIT_WRITE: assert property (
      @(posedge clock) disable iff (!resetn)
      bitWrite && !byteWrite |=>
      watch_timer_mode[$past(bitIndex)] == $past(bitValue))
      else $error("bit write not stored");

   // Divided source: the prescaler must not move away from the divider wrap
   AST_DIV_SOURCE: assert property (
      @(posedge clock) disable iff (!resetn)
      mode.timerRunEnable && !mode.countClockSourceSel && divCount != '1
      |=> prescaler == $past(prescaler))
      else $error("divided tick off its boundary");

   AST_SUB_SOURCE: assert property (
      @(posedge clock) disable iff (!resetn)
      mode.timerRunEnable && mode.countClockSourceSel && subClockTick
      |=> prescaler == $past(prescaler) + 1'b1)
      else $error("subsystem tick not counted");

   AST_WATCH_STOP: assert property (
      @(posedge clock) disable iff (!resetn)
      !bothRun |=> watchCount == '0 && !watch_overflow_irq)
      else $error("watch counter not held at zero");

   AST_WATCH_CNT: assert property (
      @(posedge clock) disable iff (!resetn)
      bothRun && countTick && prescaler[8:0] == 9'h1FF
      |=> watchCount == $past(watchCount) + 1'b1)
      else $error("watch counter missed a prescaler carry");

   AST_PRESC_KEEP: assert property (
      @(posedge clock) disable iff (!resetn)
      mode.timerRunEnable && !mode.counterRunEnable && !countTick ##1
      mode.timerRunEnable |-> prescaler == $past(prescaler))
      else $error("prescaler disturbed by counter stop");

   // Zero-second start: counter cleared, interval side keeps its phase
   AST_PRESC_RUN: assert property (
      @(posedge clock) disable iff (!resetn)
      mode.timerRunEnable && !mode.counterRunEnable && countTick
      |=> prescaler == $past(prescaler) + 1'b1 && watchCount == '0)
      else $error("prescaler stalled by counter stop");

   AST_WATCH_4: assert property (
      @(posedge clock) disable iff (!resetn)
      bothRun && countTick && mode.overflowIntervalSel == 2'h3 &&
      prescaler[3:0] == 4'hF |=> watch_overflow_irq)
      else $error("watch 2^4 request missing");

   AST_WATCH_5: assert property (
      @(posedge clock) disable iff (!resetn)
      bothRun && countTick && mode.overflowIntervalSel == 2'h2 &&
      prescaler[4:0] == 5'h1F |=> watch_overflow_irq)
      else $error("watch 2^5 request missing");

   AST_INTV_TAP: assert property (
      @(posedge clock) disable iff (!resetn)
      interval_irq |-> $past(countTick) && $past(mode.timerRunEnable))
      else $error("interval request without count tick");

   AST_INTV_16: assert property (
      @(posedge clock) disable iff (!resetn)
      countTick && mode.timerRunEnable && mode.intervalSel == 3'h0 &&
      prescaler[3:0] == 4'hF |=> interval_irq)
      else $error("interval 2^4 request missing");

   AST_INTV_STOP: assert property (
      @(posedge clock) disable iff (!resetn)
      !mode.timerRunEnable ##1 !mode.timerRunEnable |-> !interval_irq)
      else $error("interval request while stopped");

   AST_PULSE: assert property (
      @(posedge clock) disable iff (!resetn)
      interval_irq |=> !interval_irq)
      else $error("interval request longer than one cycle");

   AST_WATCH_PULSE: assert property (
      @(posedge clock) disable iff (!resetn)
      watch_overflow_irq |=> !watch_overflow_irq)
      else $error("watch request longer than one cycle");

   COV_WATCH: cover property (@(posedge clock) disable iff (!resetn)
      watch_overflow_irq);
   COV_INTV_SUB: cover property (@(posedge clock) disable iff (!resetn)
      interval_irq && mode.countClockSourceSel);
   COV_ZERO_START: cover property (@(posedge clock) disable iff (!resetn)
      mode.timerRunEnable && !mode.counterRunEnable ##1 bothRun);
   COV_WATCH_LONG: cover property (@(posedge clock) disable iff (!resetn)
      watch_overflow_irq && mode.overflowIntervalSel == 2'h0);
endmodule : wit_watch_interval_timer

// >>> src/wit_pkg.sv
// Package: constants and types of the watch and interval timer
package wit_pkg;
   localparam int WIT_DIV_BITS = 7;
   localparam int WIT_PRE_BITS = 11;
   localparam int WIT_CNT_BITS = 5;
   localparam int WIT_CNT_TAP = 9;
   localparam int WIT_INTV_BASE = 4;
   localparam logic [7:0] WIT_MODE_RESET = 8'h00;
   localparam logic [1:0] WIT_WSEL_2P14 = 2'h0;
   localparam logic [1:0] WIT_WSEL_2P13 = 2'h1;
   localparam logic [1:0] WIT_WSEL_2P5 = 2'h2;
   localparam logic [1:0] WIT_WSEL_2P4 = 2'h3;
   localparam logic [10:0] WIT_MASK_2P4 = 11'h00F;
   localparam logic [10:0] WIT_MASK_2P5 = 11'h01F;
   localparam logic [10:0] WIT_MASK_FULL = 11'h7FF;
   localparam logic [10:0] WIT_MASK_TAP = 11'h1FF;
   localparam logic [4:0] WIT_CNT_FULL = 5'h1F;
   localparam logic [4:0] WIT_CNT_HALF = 5'h0F;

   typedef struct packed {
      logic countClockSourceSel;
      logic [2:0] intervalSel;
      logic [1:0] overflowIntervalSel;
      logic counterRunEnable;
      logic timerRunEnable;
   } wit_mode_s;
endpackage : wit_pkg

// >>> tb/testbench.sv
// Testbench: directed checks of the watch and interval timer
`timescale 1ns/10ps
module testbench;
   import wit_pkg::*;
   logic clock, resetn, byteWrite, bitWrite, bitValue, subClockTick;
   logic [7:0] byteData, watch_timer_mode;
   logic [2:0] bitIndex;
   logic watch_overflow_irq, interval_irq;
   int num_errors = 0, n_compared = 0, cycles = 0, wCnt = 0, iCnt = 0;
   int n, w0, i0;
   wit_watch_interval_timer DUT (.clock(clock), .resetn(resetn),
      .byteWrite(byteWrite), .byteData(byteData), .bitWrite(bitWrite),
      .bitIndex(bitIndex), .bitValue(bitValue), .subClockTick(subClockTick),
      .watch_timer_mode(watch_timer_mode),
      .watch_overflow_irq(watch_overflow_irq), .interval_irq(interval_irq));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Pulse tallies; the ceiling sits well above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (watch_overflow_irq === 1'b1) wCnt++;
      if (interval_irq === 1'b1) iCnt++;
      if (cycles == 90000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : cmp
   task automatic finish_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // Idle edge after each write so a following call never re-raises at once
   task automatic wr(input logic [7:0] d);
      byteWrite = 1'b1;
      byteData = d;
      @(posedge clock);
      #1 byteWrite = 1'b0;
      @(posedge clock);
      #1;
   endtask : wr
   task automatic bw(input logic [2:0] idx, input logic v);
      bitWrite = 1'b1;
      bitIndex = idx;
      bitValue = v;
      @(posedge clock);
      #1 bitWrite = 1'b0;
      @(posedge clock);
      #1;
   endtask : bw
   // Cycles until the next pulse of the chosen request, bounded
   task automatic gap(input bit w, input int lim, output int k);
      k = 0;
      do begin
         @(posedge clock);
         #1 k++;
      end while (((w ? watch_overflow_irq : interval_irq) !== 1'b1) &&
                 k < lim);
   endtask : gap
   task automatic t_reg();
      cmp(watch_timer_mode, 8'h00);
      wr(8'hA5);
      cmp(watch_timer_mode, 8'hA5);
      bw(3'h6, 1'b1);
      cmp(watch_timer_mode, 8'hE5);
      bitWrite = 1'b1;
      bitIndex = 3'h0;
      bitValue = 1'b1;
      byteWrite = 1'b1;
      byteData = 8'h3C;
      @(posedge clock);
      #1 byteWrite = 1'b0;
      bitWrite = 1'b0;
      @(posedge clock);
      #1;
      cmp(watch_timer_mode, 8'h3C);
   endtask : t_reg
   task automatic t_intv();
      for (int c = 0; c < 8; c++) begin
         w0 = wCnt;
         wr({1'b1, c[2:0], 4'h1});
         gap(0, 5000, n);
         gap(0, 5000, n);
         cmp(n, 32'h1 << (4 + c));
         cmp(wCnt - w0, 0);
      end
   endtask : t_intv
   task automatic t_watch();
      logic [31:0] per [4] = '{32'h4000, 32'h2000, 32'h20, 32'h10};
      for (int c = 3; c >= 0; c--) begin
         wr({4'h8, c[1:0], 2'h0});
         wr({4'h8, c[1:0], 2'h3});
         gap(1, 40000, n);
         gap(1, 40000, n);
         cmp(n, per[c]);
      end
   endtask : t_watch
   task automatic t_stop();
      wr(8'h8F);
      gap(1, 100, n);
      bw(3'h1, 1'b0);
      w0 = wCnt;
      i0 = iCnt;
      repeat (100) @(posedge clock);
      #1;
      cmp(wCnt - w0, 0);
      cmp(iCnt > i0, 1);
      bw(3'h0, 1'b0);
      #1 i0 = iCnt;
      repeat (100) @(posedge clock);
      #1;
      cmp(iCnt - i0, 0);
   endtask : t_stop
   task automatic t_div();
      // Subsystem ticks keep coming and must be ignored here
      wr(8'h01);
      gap(0, 5000, n);
      gap(0, 5000, n);
      cmp(n, 32'h800);
   endtask : t_div
   initial begin
      resetn = 1'b0;
      byteWrite = 1'b0;
      bitWrite = 1'b0;
      bitValue = 1'b0;
      bitIndex = 3'h0;
      byteData = 8'h00;
      subClockTick = 1'b1;
      repeat (20) @(posedge clock);
      #1 resetn = 1'b1;
      t_reg();
      t_intv();
      t_watch();
      t_stop();
      t_div();
      finish_test();
   end
endmodule : testbench
